// ---- shared/tcr_pkg.sv ----
// constants shared by the timer control block and its testbench
// assumes one 100 MHz pclk and an apb master with 32-bit data
// Notes on behaviour
// RULE_01: match applies two-bit pin action per channel
// RULE_02: channel five acts only when select clear
// RULE_03: flag and enable both set request interrupt
// RULE_04: shared enable follows the channel select
// RULE_05: first mask bits gate same-position flags
// RULE_06: flags clear only by writing one
// RULE_07: compare match sets its channel flag
// RULE_08: shared flag source follows channel select
// RULE_09: capture edge sets its channel flag
// RULE_10: counter rollover sets wrap flag
// RULE_11: wrap enable gates wrap interrupt request
// RULE_12: prescale written once within 64 cycles
// RULE_13: prescale codes divide by 1,4,8,16
// RULE_14: unimplemented mask and flag bits read zero
// RULE_15: second mask high bits gate flags
// RULE_16: periodic period is clock over 2^13..2^16
// RULE_17: periodic base divider ignores timer prescaler
// RULE_18: periodic clock free-running, stopped by reset
// RULE_19: timeout sets periodic flag, may request
// RULE_20: first periodic flag after full period
// RULE_21: software clears periodic flag via bit six
// RULE_22: periodic enable gates periodic interrupt
// RULE_23: pin action happens even with flag set
// RULE_24: event wrap and edge set bits five, four
// RULE_25: writing zero keeps flag; set beats clear
// RULE_26: requests stay while flag and enable set

package tcr_pkg;

	// ****************************************
	// register byte offsets
	// ****************************************
	localparam logic [7:0] OFF_ACTION = 8'h00;
	localparam logic [7:0] OFF_MASK1 = 8'h04;
	localparam logic [7:0] OFF_FLAG1 = 8'h08;
	localparam logic [7:0] OFF_MASK2 = 8'h0C;
	localparam logic [7:0] OFF_FLAG2 = 8'h10;
	localparam logic [7:0] OFF_ACCUMULATOR_PERIODIC_CONTROL = 8'h14;

	// ****************************************
	// field positions
	// ****************************************
	localparam int F1_SHARED = 3;
	localparam int F2_WRAP = 3;
	localparam int F2_RTI = 2;
	localparam int F2_EVW = 1;
	localparam int F2_EVE = 0;
	localparam int PA_EN = 6;
	localparam int PA_MOD = 5;
	localparam int PA_EDGE = 4;
	localparam int PA_SEL = 2;

	// ****************************************
	// codes and counts
	// ****************************************
	localparam logic [1:0] ACT_OFF = 2'h0;
	localparam logic [1:0] ACT_TOGGLE = 2'h1;
	localparam logic [1:0] ACT_LOW = 2'h2;
	localparam logic [1:0] ACT_HIGH = 2'h3;
	localparam logic [1:0] PR_DIV1 = 2'h0;
	localparam logic [1:0] PR_DIV4 = 2'h1;
	localparam logic [1:0] PR_DIV8 = 2'h2;
	localparam logic [3:0] PSC_LAST_1 = 4'h0;
	localparam logic [3:0] PSC_LAST_4 = 4'h3;
	localparam logic [3:0] PSC_LAST_8 = 4'h7;
	localparam logic [3:0] PSC_LAST_16 = 4'hF;
	localparam logic [2:0] RTI_LAST_13 = 3'h0;
	localparam logic [2:0] RTI_LAST_14 = 3'h1;
	localparam logic [2:0] RTI_LAST_15 = 3'h3;
	localparam logic [2:0] RTI_LAST_16 = 3'h7;
	localparam logic [6:0] BOOT_WINDOW = 7'h40;
	localparam int RTI_BASE_EXP = 13;
	localparam logic [7:0] RST_BYTE = 8'h00;

endpackage: tcr_pkg

// ---- shared/tcr_div_if.sv ----
// run, terminal count and pulse between the control block and its divider
// assumes both ends sit on the same pclk

interface tcr_div_if;
	logic run;
	logic [15:0] last;
	logic pulse;
	modport ctl(output run, output last, input pulse);
	modport div(input run, input last, output pulse);
endinterface: tcr_div_if

// ---- core/tcr_pulse_div.sv ----
// free-running pulse divider: one pulse every last+1 cycles
// assumes run stays high outside reset for a steady period

module tcr_pulse_div (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// control side
	tcr_div_if.div dv
);

	typedef struct packed {
		logic [15:0] cnt;
		logic pulse;
	} tcr_div_state_t;

	tcr_div_state_t s;
	tcr_div_state_t n;

	// count up, wrap and pulse at the terminal value
	always_comb begin
		n = s;
		n.pulse = 1'b0;
		if (dv.run) begin
			if (s.cnt >= dv.last) begin
				n.cnt = 16'h0000;
				n.pulse = 1'b1;
			end else begin
				n.cnt = s.cnt + 16'h0001;
			end
		end
	end

	// only reset stops the chain
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign dv.pulse = s.pulse;

endmodule: tcr_pulse_div

// ---- core/tcr_timer_ctl.sv ----
// timer control: pin actions, flags, masks, prescaler, periodic timer
// assumes match, edge and wrap strobes are one-cycle pulses on pclk
//
// Added by the designer: the APB register port and the register addresses.

module tcr_timer_ctl #(
	parameter int unsigned RTI_BASE_DIV = 1 << tcr_pkg::RTI_BASE_EXP
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// operating mode
	input wire logic special_mode,
	// event strobes from the datapaths
	input wire logic [4:0] cmp_match,
	input wire logic [3:0] cap_edge,
	input wire logic ctr_wrap,
	input wire logic evt_wrap,
	input wire logic evt_edge,
	// counter clock enable
	output logic timer_tick,
	// compare pins, channels two to five
	output logic [3:0] cmp_pin_out,
	output logic [3:0] cmp_pin_oe,
	// interrupt requests
	output logic [7:0] irq_cc,
	output logic [3:0] irq_ovf_rti,
	// configuration views for neighbours
	output logic shared_channel_select,
	output logic event_counter_enable,
	output logic event_counter_mode,
	output logic event_edge_select
);

	// ****************************************
	// state
	// ****************************************

	typedef struct packed {
		logic [7:0] tctl;
		logic [7:0] msk1;
		logic [7:0] flg1;
		logic [3:0] msk2_hi;
		logic [1:0] pr;
		logic [3:0] flg2;
		logic [7:0] accumulator_periodic_control;
		logic pr_locked;
		logic [6:0] boot_cnt;
		logic [3:0] psc_cnt;
		logic [2:0] rti_cnt;
		logic [3:0] pin_lvl;
		logic [31:0] rdata;
		logic tick;
	} tcr_ctl_state_t;

	tcr_ctl_state_t s;
	tcr_ctl_state_t n;

	// ****************************************
	// helpers
	// ****************************************

	// word decode, used by write, read and error paths
	function automatic logic hit(input logic [7:0] a,
		input logic [7:0] off);
		hit = (a[7:2] == off[7:2]);
	endfunction: hit

	// prescaler terminal count per code
	function automatic logic [3:0] psc_last(input logic [1:0] pr);
		case (pr)
			tcr_pkg::PR_DIV1: psc_last = tcr_pkg::PSC_LAST_1;
			tcr_pkg::PR_DIV4: psc_last = tcr_pkg::PSC_LAST_4;
			tcr_pkg::PR_DIV8: psc_last = tcr_pkg::PSC_LAST_8;
			default: psc_last = tcr_pkg::PSC_LAST_16;
		endcase
	endfunction: psc_last

	// extra periodic division on top of the base rate
	function automatic logic [2:0] rti_last(input logic [1:0] r);
		case (r)
			2'h0: rti_last = tcr_pkg::RTI_LAST_13;
			2'h1: rti_last = tcr_pkg::RTI_LAST_14;
			2'h2: rti_last = tcr_pkg::RTI_LAST_15;
			default: rti_last = tcr_pkg::RTI_LAST_16;
		endcase
	endfunction: rti_last

	logic wr_en;
	logic rd_setup;
	logic addr_ok;
	logic sel;
	logic pr_open;
	logic base_pulse;
	logic rti_to;
	logic [7:0] set1;
	logic [7:0] clr1;
	logic [3:0] set2;
	logic [3:0] clr2;
	logic [3:0] pin_hit;
	logic [1:0] act_code [4];

	// ****************************************
	// periodic base divider
	// ****************************************

	tcr_div_if dv();

	// base clock runs apart from the timer prescaler
	assign dv.run = 1'b1; // RULE_17 RULE_18
	assign dv.last = 16'(RTI_BASE_DIV - 1); // RULE_16
	assign base_pulse = dv.pulse;

	tcr_pulse_div u_base (
		.pclk(pclk),
		.presetn(presetn),
		.dv(dv)
	);

	// ****************************************
	// decode and event vectors
	// ****************************************

	// bus phases; writes land at the access edge
	assign wr_en = psel & penable & pwrite;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign addr_ok = hit(paddr, tcr_pkg::OFF_ACTION) |
		hit(paddr, tcr_pkg::OFF_MASK1) |
		hit(paddr, tcr_pkg::OFF_FLAG1) |
		hit(paddr, tcr_pkg::OFF_MASK2) |
		hit(paddr, tcr_pkg::OFF_FLAG2) |
		hit(paddr, tcr_pkg::OFF_ACCUMULATOR_PERIODIC_CONTROL);

	assign sel = s.accumulator_periodic_control[tcr_pkg::PA_SEL];

	// prescale stays open for the boot window only in normal mode
	assign pr_open = special_mode |
		(~s.pr_locked & (s.boot_cnt < tcr_pkg::BOOT_WINDOW)); // RULE_12

	// timeout at the end of the selected multiple of base pulses
	assign rti_to = base_pulse &
		(s.rti_cnt >= rti_last(s.accumulator_periodic_control[1:0])); // RULE_16 RULE_20

	// compare, shared and capture sources in flag order
	assign set1 = {cmp_match[0], cmp_match[1], cmp_match[2],
		cmp_match[3], // RULE_07
		sel ? cap_edge[3] : cmp_match[4], // RULE_08
		cap_edge[0], cap_edge[1], cap_edge[2]}; // RULE_09

	// wrap, timeout, event wrap, event edge
	assign set2 = {ctr_wrap, rti_to, evt_wrap, evt_edge}; // RULE_10 RULE_19 RULE_24

	// write-one-to-clear masks; zeros leave flags alone
	assign clr1 = (wr_en && hit(paddr, tcr_pkg::OFF_FLAG1)) ?
		pwdata[7:0] : 8'h00; // RULE_06
	assign clr2 = (wr_en && hit(paddr, tcr_pkg::OFF_FLAG2)) ?
		pwdata[7:4] : 4'h0; // RULE_06 RULE_21

	// ****************************************
	// compare pin decode
	// ****************************************

	// match g+1 drives pin g for compare channels two to five
	genvar g;
	for (g = 0; g < 4; g++) begin: g_pin
		assign act_code[g] = s.tctl[(7 - 2 * g) -: 2];
		// channel five is muted while the pin captures
		if (g == 3) begin: g_shared
			assign pin_hit[g] = cmp_match[g + 1] & ~sel; // RULE_02
			assign cmp_pin_oe[g] =
				(act_code[g] != tcr_pkg::ACT_OFF) & ~sel;
		end else begin: g_plain
			assign pin_hit[g] = cmp_match[g + 1];
			assign cmp_pin_oe[g] = (act_code[g] != tcr_pkg::ACT_OFF); // RULE_01
		end
	end

	// ****************************************
	// next state
	// ****************************************

	always_comb begin
		n = s;
		n.tick = 1'b0;

		// count bus cycles since reset, saturating
		if (s.boot_cnt < tcr_pkg::BOOT_WINDOW) begin
			n.boot_cnt = s.boot_cnt + 7'h01;
		end

		// register writes
		if (wr_en) begin
			if (hit(paddr, tcr_pkg::OFF_ACTION)) begin
				n.tctl = pwdata[7:0];
			end else if (hit(paddr, tcr_pkg::OFF_MASK1)) begin
				n.msk1 = pwdata[7:0];
			end else if (hit(paddr, tcr_pkg::OFF_MASK2)) begin
				n.msk2_hi = pwdata[7:4];
				// outside special mode, later writes only move the enables
				if (pr_open) begin
					n.pr = pwdata[1:0]; // RULE_12
					n.pr_locked = 1'b1;
				end
			end else if (hit(paddr, tcr_pkg::OFF_ACCUMULATOR_PERIODIC_CONTROL)) begin
				n.accumulator_periodic_control = pwdata[7:0];
			end
		end

		// set wins over a clear in the same cycle
		n.flg1 = (s.flg1 & ~clr1) | set1; // RULE_25
		n.flg2 = (s.flg2 & ~clr2) | set2; // RULE_25

		// prescaler: one counter tick every 1, 4, 8 or 16 cycles
		if (s.psc_cnt >= psc_last(s.pr)) begin
			n.psc_cnt = 4'h0; // RULE_13
			n.tick = 1'b1;
		end else begin
			n.psc_cnt = s.psc_cnt + 4'h1;
		end

		// period counts from the last timeout, never from a clear
		if (base_pulse) begin
			if (rti_to) begin
				n.rti_cnt = 3'h0; // RULE_18
			end else begin
				n.rti_cnt = s.rti_cnt + 3'h1;
			end
		end

		// pin actions on every unmuted match, flag state does not matter
		for (int i = 0; i < 4; i++) begin
			if (pin_hit[i]) begin
				case (act_code[i])
					tcr_pkg::ACT_TOGGLE: n.pin_lvl[i] = ~s.pin_lvl[i]; // RULE_01 RULE_23
					tcr_pkg::ACT_LOW: n.pin_lvl[i] = 1'b0;
					tcr_pkg::ACT_HIGH: n.pin_lvl[i] = 1'b1;
					default: n.pin_lvl[i] = s.pin_lvl[i];
				endcase
			end
		end

		// read data captured in setup, valid through access
		if (rd_setup) begin
			if (hit(paddr, tcr_pkg::OFF_ACTION)) begin
				n.rdata = {24'h000000, s.tctl};
			end else if (hit(paddr, tcr_pkg::OFF_MASK1)) begin
				n.rdata = {24'h000000, s.msk1};
			end else if (hit(paddr, tcr_pkg::OFF_FLAG1)) begin
				n.rdata = {24'h000000, s.flg1};
			end else if (hit(paddr, tcr_pkg::OFF_MASK2)) begin
				n.rdata = {24'h000000, s.msk2_hi, 2'h0, s.pr}; // RULE_14
			end else if (hit(paddr, tcr_pkg::OFF_FLAG2)) begin
				n.rdata = {24'h000000, s.flg2, 4'h0}; // RULE_14
			end else if (hit(paddr, tcr_pkg::OFF_ACCUMULATOR_PERIODIC_CONTROL)) begin
				n.rdata = {24'h000000, s.accumulator_periodic_control};
			end else begin
				n.rdata = 32'h00000000;
			end
		end
	end

	// ****************************************
	// state register
	// ****************************************

	// everything clears to zero; pins start low and released
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	// ****************************************
	// outputs
	// ****************************************

	// zero wait states; unmapped words answer with an error
	assign pready = psel & penable;
	assign pslverr = psel & penable & ~addr_ok;
	assign prdata = s.rdata;

	assign timer_tick = s.tick;
	assign cmp_pin_out = s.pin_lvl;

	// level requests, dropping with flag or enable
	assign irq_cc = s.flg1 & s.msk1; // RULE_03 RULE_04 RULE_05 RULE_26
	assign irq_ovf_rti = s.flg2 & s.msk2_hi; // RULE_11 RULE_15 RULE_22 RULE_26

	assign shared_channel_select = sel;
	assign event_counter_enable = s.accumulator_periodic_control[tcr_pkg::PA_EN];
	assign event_counter_mode = s.accumulator_periodic_control[tcr_pkg::PA_MOD];
	assign event_edge_select = s.accumulator_periodic_control[tcr_pkg::PA_EDGE];

	// ****************************************
	// checks
	// ****************************************

	match_flag_a: assert property ( // RULE_07
		@(posedge pclk) disable iff (!presetn)
		cmp_match[0] |=> s.flg1[7])
		else $error("compare match did not set its flag");

	wrap_flag_a: assert property ( // RULE_10
		@(posedge pclk) disable iff (!presetn)
		ctr_wrap |=> s.flg2[tcr_pkg::F2_WRAP] ##1
			s.flg2[tcr_pkg::F2_WRAP] || $past(clr2[tcr_pkg::F2_WRAP]))
		else $error("rollover did not set wrap flag");

	flag_clear_a: assert property ( // RULE_06
		@(posedge pclk) disable iff (!presetn)
		wr_en && hit(paddr, tcr_pkg::OFF_FLAG1) && pwdata[0] &&
		!cap_edge[2] |=> !s.flg1[0])
		else $error("write one did not clear flag");

	set_wins_a: assert property ( // RULE_25
		@(posedge pclk) disable iff (!presetn)
		clr1[7] && cmp_match[0] |=> s.flg1[7] && irq_cc[7] == s.msk1[7])
		else $error("set lost against clear");

	irq_level_a: assert property ( // RULE_26
		@(posedge pclk) disable iff (!presetn)
		s.flg2[tcr_pkg::F2_RTI] && s.msk2_hi[tcr_pkg::F2_RTI] |->
			irq_ovf_rti[tcr_pkg::F2_RTI])
		else $error("periodic request missing");

	prescale_lock_a: assert property ( // RULE_12
		@(posedge pclk) disable iff (!presetn)
		s.pr_locked && !special_mode |=> $stable(s.pr))
		else $error("prescale changed after lock");

	tick_rate_a: assert property ( // RULE_13
		@(posedge pclk) disable iff (!presetn)
		s.tick && s.pr == 2'h3 && s.pr_locked && !special_mode |=>
			!s.tick [*8])
		else $error("divide by sixteen ticked early");

	shared_mute_a: assert property ( // RULE_02
		@(posedge pclk) disable iff (!presetn)
		sel && cmp_match[4] |=> $stable(s.pin_lvl[3]) && !cmp_pin_oe[3])
		else $error("channel five acted while capturing");

	toggle_act_a: assert property ( // RULE_01
		@(posedge pclk) disable iff (!presetn)
		cmp_match[1] && s.tctl[7:6] == tcr_pkg::ACT_TOGGLE |=>
			s.pin_lvl[0] != $past(s.pin_lvl[0]))
		else $error("toggle action not applied");

	rti_flag_a: assert property ( // RULE_19
		@(posedge pclk) disable iff (!presetn)
		rti_to |=> s.flg2[tcr_pkg::F2_RTI] && s.rti_cnt == 3'h0)
		else $error("timeout did not set periodic flag");

endmodule: tcr_timer_ctl

// ---- bench/tcr_pin_model.sv ----
// pin model: the four compare pins as seen from outside the device
// assumes a pull-up on every pin, so a released pin reads high

module tcr_pin_model (
	// pins from the device
	input wire logic [3:0] pin_out,
	input wire logic [3:0] pin_oe,
	// resolved pin levels
	output logic [3:0] pin_lvl
);
	timeunit 1ns;
	timeprecision 100ps;

	// a released pin shows the pull-up, never the stale driven value
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			pin_lvl[i] = pin_oe[i] ? pin_out[i] : 1'b1;
		end
	end
endmodule: tcr_pin_model

// ---- bench/timer_compare_rti_control_tb.sv ----
// testbench: apb register tasks and event strobes around the timer control
// assumes the package, interface, design and pin model compile first

`define CHK(got, exp) begin \
	num_checks++; \
	if ((got) !== (exp)) begin \
		n_fail++; \
		$display("CHECK FAILED t=%0t got %0h want %0h", $time, got, exp); \
	end \
end

module timer_compare_rti_control_tb;
	timeunit 1ns;
	timeprecision 100ps;

	// ****************************************
	// signals
	// ****************************************
	// short periodic base keeps the run small
	localparam int RTI_DIV = 16;
	localparam int BOUND = 4000;
	logic pclk, presetn, psel, penable, pwrite, special_mode, perr;
	logic [7:0] paddr, irq_cc;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, ctr_wrap, evt_wrap, evt_edge, timer_tick;
	logic sel_view, ev_en, ev_mode, ev_edge_sel;
	logic [4:0] cmp_match;
	logic [3:0] cap_edge, pin_out, pin_oe, pin_lvl, irq2;
	logic [7:0] acts [5] = '{8'h55, 8'h55, 8'hFF, 8'hAA, 8'h00};
	logic [3:0] lvls [5] = '{4'hF, 4'h0, 4'hF, 4'h0, 4'hF};
	int n_fail, num_checks, cyc, t0, t1, t2, n;

	tcr_timer_ctl #(.RTI_BASE_DIV(RTI_DIV)) i_dut (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .special_mode(special_mode),
		.cmp_match(cmp_match), .cap_edge(cap_edge), .ctr_wrap(ctr_wrap),
		.evt_wrap(evt_wrap), .evt_edge(evt_edge), .timer_tick(timer_tick),
		.cmp_pin_out(pin_out), .cmp_pin_oe(pin_oe), .irq_cc(irq_cc),
		.irq_ovf_rti(irq2), .shared_channel_select(sel_view),
		.event_counter_enable(ev_en), .event_counter_mode(ev_mode),
		.event_edge_select(ev_edge_sel));
	tcr_pin_model i_pins (.pin_out(pin_out), .pin_oe(pin_oe),
		.pin_lvl(pin_lvl));

	// ****************************************
	// tasks
	// ****************************************
	task automatic conclude();
		$display("checks %0d failures %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask: conclude

	task automatic timeout();
		n_fail++;
		conclude();
	endtask: timeout

	// one full apb transfer; request held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [7:0] d, output logic [31:0] q);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (i == 16) timeout();
		q = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask: apb

	// outputs settle after the access edge, so wait half a cycle to sample
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, d, rd);
		@(negedge pclk);
	endtask: wr

	task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
		apb(1'b0, a, 8'h00, rd);
		`CHK(rd, {24'h0, e})
	endtask: rdchk

	// strobes last one cycle, then one more edge lets the flags land
	task automatic strobe(input logic [4:0] m, input logic [3:0] c,
		input logic [2:0] w);
		@(posedge pclk);
		cmp_match <= m;
		cap_edge <= c;
		{ctr_wrap, evt_wrap, evt_edge} <= w;
		@(posedge pclk);
		cmp_match <= 5'h00;
		cap_edge <= 4'h0;
		{ctr_wrap, evt_wrap, evt_edge} <= 3'h0;
		@(posedge pclk);
	endtask: strobe

	task automatic do_reset();
		presetn <= 1'b0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t0 = cyc;
	endtask: do_reset

	// rising edge of the periodic request, as a cycle number
	task automatic wait_rti(output int t);
		logic prev;
		int i;
		prev = irq2[2];
		for (i = 0; i < BOUND; i++) begin
			@(posedge pclk);
			if (irq2[2] === 1'b1 && prev !== 1'b1) break;
			prev = irq2[2];
		end
		if (i == BOUND) timeout();
		t = cyc;
	endtask: wait_rti

	// ****************************************
	// clock and sequence
	// ****************************************
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	always @(posedge pclk) cyc <= cyc + 1;

	initial begin
		{presetn, psel, penable, pwrite, special_mode, perr} = '0;
		{ctr_wrap, evt_wrap, evt_edge, paddr, pwdata} = '0;
		{cmp_match, cap_edge, n_fail, num_checks, cyc} = '0;
		do_reset();
		for (int k = 0; k < 6; k++) rdchk(8'(4 * k), 8'h00);
		apb(1'b0, 8'h18, 8'h00, rd);
		`CHK({perr, rd}, 33'h1_0000_0000)
		// prescale write after the boot window is dropped
		repeat (70) @(posedge pclk);
		wr(tcr_pkg::OFF_MASK2, 8'h03);
		rdchk(tcr_pkg::OFF_MASK2, 8'h00);
		// special mode keeps the prescale field writable after the window
		special_mode <= 1'b1;
		wr(tcr_pkg::OFF_MASK2, 8'h01);
		rdchk(tcr_pkg::OFF_MASK2, 8'h01);
		special_mode <= 1'b0;
		for (int c = 0; c < 4; c++) begin
			do_reset();
			wr(tcr_pkg::OFF_ACCUMULATOR_PERIODIC_CONTROL, 8'(c));
			wr(tcr_pkg::OFF_MASK2, {6'h10, 2'(c)});
			wait_rti(t1);
			`CHK(t1 - t0 >= RTI_DIV << c && t1 - t0 <= (RTI_DIV << c) + 3, 1'b1)
			wr(tcr_pkg::OFF_FLAG2, 8'h40);
			wait_rti(t2);
			`CHK(t2 - t1, RTI_DIV << c)
			wr(tcr_pkg::OFF_MASK2, {6'h10, 2'(~c)});
			rdchk(tcr_pkg::OFF_MASK2, {6'h10, 2'(c)});
			n = 0;
			repeat (64) begin
				@(posedge pclk);
				if (timer_tick === 1'b1) n++;
			end
			`CHK(n, 64 >> (c == 0 ? 0 : c + 1))
		end
		wr(tcr_pkg::OFF_ACCUMULATOR_PERIODIC_CONTROL, 8'h74);
		`CHK({sel_view, ev_en, ev_mode, ev_edge_sel}, 4'hF)
		wr(tcr_pkg::OFF_ACCUMULATOR_PERIODIC_CONTROL, 8'h03);
		for (int k = 0; k < 5; k++) begin
			wr(tcr_pkg::OFF_ACTION, acts[k]);
			strobe(5'h1E, 4'h0, 3'h0);
			`CHK(pin_lvl, lvls[k])
		end
		wr(tcr_pkg::OFF_ACCUMULATOR_PERIODIC_CONTROL, 8'h07);
		wr(tcr_pkg::OFF_ACTION, 8'hFF);
		strobe(5'h1E, 4'h0, 3'h0);
		`CHK({pin_oe[3], pin_out}, 5'h07)
		wr(tcr_pkg::OFF_FLAG1, 8'hFF);
		rdchk(tcr_pkg::OFF_FLAG1, 8'h00);
		strobe(5'h1F, 4'h7, 3'h0);
		rdchk(tcr_pkg::OFF_FLAG1, 8'hF7);
		strobe(5'h00, 4'h8, 3'h0);
		rdchk(tcr_pkg::OFF_FLAG1, 8'hFF);
		wr(tcr_pkg::OFF_MASK1, 8'hA5);
		`CHK(irq_cc, 8'hA5)
		wr(tcr_pkg::OFF_FLAG1, 8'h00);
		rdchk(tcr_pkg::OFF_FLAG1, 8'hFF);
		wr(tcr_pkg::OFF_FLAG1, 8'h0F);
		rdchk(tcr_pkg::OFF_FLAG1, 8'hF0);
		`CHK(irq_cc, 8'hA0)
		wr(tcr_pkg::OFF_ACCUMULATOR_PERIODIC_CONTROL, 8'h03);
		wr(tcr_pkg::OFF_MASK1, 8'h08);
		strobe(5'h00, 4'h8, 3'h0);
		`CHK(irq_cc, 8'h00)
		strobe(5'h10, 4'h0, 3'h0);
		`CHK(irq_cc, 8'h08)
		// match strobe lands on the same edge as the clearing write
		fork
			wr(tcr_pkg::OFF_FLAG1, 8'h80);
			begin
				@(posedge pclk);
				strobe(5'h01, 4'h0, 3'h0);
			end
		join
		rdchk(tcr_pkg::OFF_FLAG1, 8'hF8);
		wr(tcr_pkg::OFF_FLAG2, 8'hF0);
		strobe(5'h00, 4'h0, 3'h7);
		apb(1'b0, tcr_pkg::OFF_FLAG2, 8'h00, rd);
		`CHK(rd & 32'hBF, 32'hB0)
		wr(tcr_pkg::OFF_MASK2, 8'hF0);
		`CHK(irq2 & 4'hB, 4'hB)
		wr(tcr_pkg::OFF_MASK2, 8'h00);
		`CHK(irq2, 4'h0)
		conclude();
	end
endmodule: timer_compare_rti_control_tb
